// [rtl/uart_fc_pkg.sv]
/*
  constants and types shared by the flow-controlled serial port.
  assumes a single 125 MHz clock and synchronous active-high reset.
*/
// Notes on behaviour
// - full duplex transmit and receive at once, baud up to one megabit.
// - with parity on, send a ninth parity bit and check it on receive.
// - drive request-to-send to pace host; sample clear-to-send before sending.
// - both handshake lines are active low.
// - data lines rest high when no character is sent.
// - line polarity is inverse of an RS-232 cable; converters must invert.
// - transmit pin is an output driven high once set up.
// - receive pin has a pull-up so an undriven line reads idle.
// - request-to-send output starts driven low, inviting the host to send.
// - clear-to-send input has a pull-down so unconnected reads asserted.
package uart_fc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MAX_BAUD = 1_000_000;
  localparam int unsigned DEF_BAUD = 115_200;
  // 16x oversampling tick
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned DIV_W = 16;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic HS_ASSERT = 1'b0;
  localparam logic HS_DEASSERT = 1'b1;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam int unsigned DATA_BITS = 8;

  function automatic logic [DIV_W-1:0] baud_div(input int unsigned baud);
    baud_div = DIV_W'(CLK_HZ / (baud * OVERSAMPLE) - 1);
  endfunction

  function automatic logic odd_even_parity(input logic [7:0] d,
                                           input logic odd);
    odd_even_parity = (^d) ^ odd;
  endfunction

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_START  = 5'h02,
    ST_DATA   = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP   = 5'h10
  } ser_state_t;
endpackage

// [rtl/uart_fc_tx.sv]
/*
  transmit engine: sends one character per request, lsb first.
  assumes tick is a one-cycle 16x oversample enable.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_fc_tx
  import uart_fc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic tick,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic cts_ok,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic txd
);
  typedef struct packed {
    ser_state_t st;
    logic [3:0] sub;
    logic [3:0] bitn;
    logic [7:0] shf;
    logic par;
    logic txd;
  } tx_s_t;
  tx_s_t s_ff, nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.txd = LINE_IDLE;
        // clear-to-send gates only the start of a character
        if (start && cts_ok)
        begin
          nxt_s.st = ST_START;
          nxt_s.shf = data;
          nxt_s.par = odd_even_parity(data, parity_odd);
          nxt_s.sub = BIT_ZERO;
          nxt_s.txd = LINE_START;
        end
      end
      ST_START, ST_DATA, ST_PARITY, ST_STOP:
      begin
        if (tick)
        begin
          nxt_s.sub = s_ff.sub + 4'h1;
          if (s_ff.sub == LAST_TICK)
          begin
            case (s_ff.st)
              ST_START:
              begin
                nxt_s.st = ST_DATA;
                nxt_s.bitn = BIT_ZERO;
                nxt_s.txd = s_ff.shf[0];
              end
              ST_DATA:
              begin
                nxt_s.shf = {1'b0, s_ff.shf[7:1]};
                nxt_s.bitn = s_ff.bitn + 4'h1;
                if (s_ff.bitn == 4'(DATA_BITS - 1))
                begin
                  nxt_s.st = parity_en ? ST_PARITY : ST_STOP;
                  nxt_s.txd = parity_en ? s_ff.par : LINE_IDLE;
                end
                else
                  nxt_s.txd = s_ff.shf[1];
              end
              ST_PARITY:
              begin
                nxt_s.st = ST_STOP;
                nxt_s.txd = LINE_IDLE;
              end
              default:
              begin
                nxt_s.st = ST_IDLE;
                nxt_s.txd = LINE_IDLE;
              end
            endcase
          end
        end
      end
      default:
      begin
        nxt_s.st = ST_IDLE;
        nxt_s.txd = LINE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.txd <= LINE_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  assign busy = (s_ff.st != ST_IDLE);
  assign txd = s_ff.txd;

  AST_TX_START_LOW: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.st == ST_IDLE && start && cts_ok) |=> (txd == LINE_START))
    else $error("start bit not low");
  AST_TX_NO_CTS: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.st == ST_IDLE && !cts_ok) |=> (s_ff.st == ST_IDLE))
    else $error("sent without clear-to-send");
  AST_TX_IDLE_HIGH: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.st == ST_IDLE && $past(s_ff.st) == ST_IDLE) |-> txd)
    else $error("idle line not high");
endmodule
`default_nettype wire

// [rtl/uart_fc_rx.sv]
/*
  receive engine: 16x oversampled, samples mid-bit, checks parity.
  assumes rxd already synchronised and tick a one-cycle enable.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_fc_rx
  import uart_fc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic tick,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic rxd,
  output logic done,
  output logic [7:0] data,
  output logic parity_err,
  output logic frame_err
);
  typedef struct packed {
    ser_state_t st;
    logic [3:0] sub;
    logic [3:0] bitn;
    logic [7:0] shf;
    logic par;
    logic done;
    logic perr;
    logic ferr;
  } rx_s_t;
  rx_s_t s_ff, nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      ST_IDLE:
      begin
        if (rxd == LINE_START)
        begin
          nxt_s.st = ST_START;
          nxt_s.sub = BIT_ZERO;
        end
      end
      ST_START, ST_DATA, ST_PARITY, ST_STOP:
      begin
        if (tick)
        begin
          nxt_s.sub = s_ff.sub + 4'h1;
          if (s_ff.sub == MID_SAMPLE)
          begin
            nxt_s.sub = BIT_ZERO;
            case (s_ff.st)
              ST_START:
              begin
                // a glitch shorter than half a bit is not a start
                nxt_s.st = (rxd == LINE_START) ? ST_DATA : ST_IDLE;
                nxt_s.bitn = BIT_ZERO;
                nxt_s.sub = (rxd == LINE_START) ? BIT_ZERO : s_ff.sub;
              end
              ST_DATA:
              begin
                nxt_s.sub = s_ff.sub + 4'h1;
                nxt_s.st = s_ff.st;
              end
              default:
                nxt_s.sub = s_ff.sub + 4'h1;
            endcase
          end
          else if (s_ff.sub == LAST_TICK && s_ff.st != ST_START)
          begin
            nxt_s.sub = BIT_ZERO;
          end
          // start phase realigned to mid-bit; later bits sampled a bit apart
          if (s_ff.st != ST_START && s_ff.sub == LAST_TICK)
          begin
            case (s_ff.st)
              ST_DATA:
              begin
                nxt_s.shf = {rxd, s_ff.shf[7:1]};
                nxt_s.bitn = s_ff.bitn + 4'h1;
                if (s_ff.bitn == 4'(DATA_BITS - 1))
                  nxt_s.st = parity_en ? ST_PARITY : ST_STOP;
              end
              ST_PARITY:
              begin
                nxt_s.par = rxd;
                nxt_s.st = ST_STOP;
              end
              default:
              begin
                nxt_s.st = ST_IDLE;
                nxt_s.done = 1'b1;
                nxt_s.ferr = (rxd != LINE_IDLE);
                nxt_s.perr = parity_en &&
                  (odd_even_parity(s_ff.shf, parity_odd) != s_ff.par);
              end
            endcase
          end
        end
      end
      default:
        nxt_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  assign done = s_ff.done;
  assign data = s_ff.shf;
  assign parity_err = s_ff.perr;
  assign frame_err = s_ff.ferr;

  AST_RX_DONE_PULSE: assert property (
    @(posedge mclk) disable iff (reset)
    done |=> !done)
    else $error("done longer than one cycle");
  AST_RX_NO_PERR_OFF: assert property (
    @(posedge mclk) disable iff (reset)
    (done && !parity_en) |-> !parity_err)
    else $error("parity error with parity off");
endmodule
`default_nettype wire

// [rtl/uart_fc_top.sv]
/*
  flow-controlled serial port: full-duplex transmit and receive engines,
  a receive buffer that drives request-to-send, and clear-to-send gating.
  assumes one 125 MHz clock, pins already synchronous, pulls at the pads.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_fc_top
  import uart_fc_pkg::*;
#(
  parameter int unsigned BAUD = DEF_BAUD,
  parameter int unsigned RX_DEPTH = 16,
  parameter int unsigned RTS_MARGIN = 4
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_overrun,
  input wire logic overrun_clr,
  input wire logic uart_rxd,
  output logic uart_txd,
  output logic uart_rts_n,
  input wire logic uart_cts_n
);
  localparam int unsigned AW = $clog2(RX_DEPTH);
  localparam logic [DIV_W-1:0] DIV = baud_div(BAUD);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(RX_DEPTH);
  localparam logic [AW:0] STOP_CNT = (AW+1)'(RX_DEPTH - RTS_MARGIN);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [1:0] rx_sync;
    logic cts_s;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [7:0] rdat;
    logic rval;
    logic perr;
    logic ferr;
    logic ovr;
    logic rts_n;
    logic txd;
    logic txrdy;
  } top_s_t;
  top_s_t s_ff, nxt_s;

  // each entry keeps its own error bits so they leave with the character
  typedef struct packed {
    logic ferr;
    logic perr;
    logic [7:0] dat;
  } rx_ent_t;
  rx_ent_t mem [RX_DEPTH];
  logic tx_busy;
  logic tx_line;
  logic rx_done;
  logic [7:0] rx_word;
  logic rx_perr;
  logic rx_ferr;
  logic tx_go;
  logic push;
  logic pop;

  // send handshake: host asserts clear-to-send by pulling low
  assign tx_go = tx_valid && s_ff.txrdy && (s_ff.cts_s == HS_ASSERT);
  assign pop = (!s_ff.rval || rx_ready) && (s_ff.cnt != '0);
  // overrun drops the character rather than corrupt older data
  assign push = rx_done && (s_ff.cnt != FULL_CNT);

  uart_fc_tx u_tx (
    .mclk(mclk),
    .reset(reset),
    .tick(s_ff.tick),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .cts_ok(s_ff.cts_s == HS_ASSERT),
    .start(tx_go),
    .data(tx_data),
    .busy(tx_busy),
    .txd(tx_line)
  );

  uart_fc_rx u_rx (
    .mclk(mclk),
    .reset(reset),
    .tick(s_ff.tick),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .rxd(s_ff.rx_sync[1]),
    .done(rx_done),
    .data(rx_word),
    .parity_err(rx_perr),
    .frame_err(rx_ferr)
  );

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.div == '0)
    begin
      nxt_s.div = DIV;
      nxt_s.tick = 1'b1;
    end
    else
      nxt_s.div = s_ff.div - 1'b1;
    nxt_s.rx_sync = {s_ff.rx_sync[0], uart_rxd};
    nxt_s.cts_s = uart_cts_n;
    nxt_s.txd = tx_line;
    nxt_s.txrdy = !tx_busy && !tx_go && !s_ff.txrdy ? 1'b1 :
                  (tx_go ? 1'b0 : (!tx_busy && s_ff.txrdy));
    if (push)
      nxt_s.wp = s_ff.wp + 1'b1;
    if (pop)
    begin
      nxt_s.rp = s_ff.rp + 1'b1;
      nxt_s.rdat = mem[s_ff.rp].dat;
      nxt_s.rval = 1'b1;
      nxt_s.perr = mem[s_ff.rp].perr;
      nxt_s.ferr = mem[s_ff.rp].ferr;
    end
    else if (rx_ready)
      nxt_s.rval = 1'b0;
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // set wins over clear
    if (overrun_clr)
      nxt_s.ovr = 1'b0;
    if (rx_done && !push)
      nxt_s.ovr = 1'b1;
    // deassert early so characters in flight still fit
    nxt_s.rts_n = (nxt_s.cnt >= STOP_CNT) ? HS_DEASSERT : HS_ASSERT;
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[s_ff.wp] <= {rx_ferr, rx_perr, rx_word};
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.rx_sync <= {LINE_IDLE, LINE_IDLE};
      s_ff.cts_s <= HS_ASSERT;
      s_ff.rts_n <= HS_ASSERT;
      s_ff.txd <= LINE_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // pins are true logic levels: idle high, handshake low means asserted,
  // so an external RS-232 driver must invert every line
  assign uart_txd = s_ff.txd;
  assign uart_rts_n = s_ff.rts_n;
  assign tx_ready = s_ff.txrdy;
  assign rx_data = s_ff.rdat;
  assign rx_valid = s_ff.rval;
  assign rx_parity_err = s_ff.perr;
  assign rx_frame_err = s_ff.ferr;
  assign rx_overrun = s_ff.ovr;

  AST_RTS_FULL: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.cnt >= STOP_CNT) |-> (uart_rts_n == HS_DEASSERT))
    else $error("rts asserted with buffer near full");
  AST_RTS_FREE: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.cnt < STOP_CNT) |-> (uart_rts_n == HS_ASSERT))
    else $error("rts withheld with room free");
  AST_OVERRUN_SET: assert property (
    @(posedge mclk) disable iff (reset)
    (rx_done && s_ff.cnt == FULL_CNT) |=> rx_overrun)
    else $error("overrun not flagged");
  AST_CTS_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (s_ff.cts_s == HS_DEASSERT && !tx_busy) |=> !tx_busy)
    else $error("character started without clear-to-send");
  AST_TXD_IDLE: assert property (
    @(posedge mclk) disable iff (reset)
    (!tx_busy && !$past(tx_busy)) |=> uart_txd)
    else $error("txd not high while idle");
  AST_DUPLEX: assert property (
    @(posedge mclk) disable iff (reset)
    (tx_busy && rx_done && s_ff.cnt < FULL_CNT) |=> s_ff.cnt != '0)
    else $error("receive lost during transmit");
  AST_TX_TAKEN: assert property (
    @(posedge mclk) disable iff (reset)
    tx_go |=> (!tx_ready && tx_busy))
    else $error("character request not taken");
  // pin lags the engine by one register stage
  AST_START_ON_PIN: assert property (
    @(posedge mclk) disable iff (reset)
    tx_go |-> ##2 (uart_txd == LINE_START))
    else $error("start bit missing on pin");
  AST_RX_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (rx_valid && !rx_ready) |=> (rx_valid && $stable(rx_data)))
    else $error("received character dropped before accept");
  AST_ERR_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (rx_valid && !rx_ready) |=> $stable(rx_parity_err))
    else $error("parity flag changed under a held character");
  AST_CNT_MAX: assert property (
    @(posedge mclk) disable iff (reset)
    s_ff.cnt <= FULL_CNT)
    else $error("buffer count beyond depth");
  AST_OVR_STICKY: assert property (
    @(posedge mclk) disable iff (reset)
    (rx_overrun && !overrun_clr) |=> rx_overrun)
    else $error("overrun flag lost without clear");
  AST_OVR_CLEAR: assert property (
    @(posedge mclk) disable iff (reset)
    (overrun_clr && !rx_done) |=> !rx_overrun)
    else $error("overrun flag not cleared");
  AST_CTS_SAMPLED: assert property (
    @(posedge mclk) disable iff (reset)
    (uart_cts_n == HS_DEASSERT) |=> (s_ff.cts_s == HS_DEASSERT))
    else $error("clear-to-send deassert missed");
  AST_TICK_PULSE: assert property (
    @(posedge mclk) disable iff (reset)
    s_ff.tick |=> !s_ff.tick)
    else $error("baud tick longer than one cycle");
endmodule
`default_nettype wire

// [verif/host_uart_model.sv]
/*
  behavioural host serial port facing the flow-controlled port.
  assumes mclk shared with the port and a fixed bit period in cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module host_uart_model
  import uart_fc_pkg::*;
#(
  parameter int BIT_CYC = 112
)
(
  input wire logic mclk,
  input wire logic dev_txd,
  input wire logic dev_rts_n,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic cts_n_req,
  output logic host_txd,
  output logic host_cts_n
);
  import uart_fc_pkg::*;
  logic [7:0] got;
  logic got_par;
  logic got_stop;
  int got_cnt;

  assign host_cts_n = cts_n_req;
  initial host_txd = LINE_IDLE;

  // ignore_rts exists only to push data into a full buffer on purpose
  task automatic send(input logic [7:0] d, input logic bad,
                      input logic ignore_rts);
    logic [10:0] f;
    int n;
    if (!ignore_rts)
      while (dev_rts_n !== HS_ASSERT) @(posedge mclk);
    f = {LINE_IDLE, (^d) ^ par_odd ^ bad, d, LINE_START};
    if (!par_en)
      f[9] = LINE_IDLE;
    n = par_en ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      host_txd <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask

  // receiver samples mid-bit on the port's transmit line
  initial
  begin
    got_cnt = 0;
    forever
    begin
      @(negedge dev_txd);
      repeat (BIT_CYC / 2) @(posedge mclk);
      if (dev_txd === LINE_START)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYC) @(posedge mclk);
          got[i] = dev_txd;
        end
        if (par_en)
        begin
          repeat (BIT_CYC) @(posedge mclk);
          got_par = dev_txd;
        end
        repeat (BIT_CYC) @(posedge mclk);
        got_stop = dev_txd;
        got_cnt++;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/uart_with_rts_cts_flow_control_test.sv]
/*
  self-checking bench for the flow-controlled serial port.
  assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_with_rts_cts_flow_control_test;
  import uart_fc_pkg::*;
  // fastest legal rate keeps the run short
  localparam int unsigned BAUD = 1_000_000;
  localparam int BIT_CYC = (CLK_HZ / (BAUD * OVERSAMPLE)) * OVERSAMPLE;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic parity_en = 1'b0;
  logic parity_odd = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic overrun_clr = 1'b0;
  logic cts_req = 1'b0;
  logic tx_ready, rx_valid, rx_parity_err, rx_frame_err, rx_overrun;
  logic [7:0] rx_data;
  logic uart_rxd, uart_txd, uart_rts_n, uart_cts_n;
  int mismatches = 0;
  int n_compared = 0;

  uart_fc_top #(.BAUD(BAUD)) DUT (.mclk(mclk), .reset(reset),
    .parity_en(parity_en), .parity_odd(parity_odd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .rx_overrun(rx_overrun), .overrun_clr(overrun_clr),
    .uart_rxd(uart_rxd), .uart_txd(uart_txd), .uart_rts_n(uart_rts_n),
    .uart_cts_n(uart_cts_n));
  host_uart_model #(.BIT_CYC(BIT_CYC)) host (.mclk(mclk),
    .dev_txd(uart_txd), .dev_rts_n(uart_rts_n), .par_en(parity_en),
    .par_odd(parity_odd), .cts_n_req(cts_req), .host_txd(uart_rxd),
    .host_cts_n(uart_cts_n));

  initial forever #4 mclk = ~mclk;

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic tx_byte(input logic [7:0] d);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 3000)
    begin
      settle(1);
      n++;
    end
    check("tx_ready", 8'h01, {7'h00, tx_ready});
    @(posedge mclk);
    tx_data <= d;
    tx_valid <= 1'b1;
    n = 0;
    do
    begin
      settle(1);
      n++;
    end
    while (tx_ready !== 1'b0 && n < 3000);
    check("tx taken", 8'h00, {7'h00, tx_ready});
    @(posedge mclk);
    tx_valid <= 1'b0;
  endtask

  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 3000)
    begin
      settle(1);
      n++;
    end
    check("rx_valid", 8'h01, {7'h00, rx_valid});
    check("rx_data", exp, rx_data);
    @(posedge mclk);
    rx_ready <= 1'b1;
    @(posedge mclk);
    rx_ready <= 1'b0;
    settle(1);
  endtask

  task automatic t_reset();
    check("txd idle", 8'h01, {7'h00, uart_txd});
    check("rts after reset", 8'h00, {7'h00, uart_rts_n});
    check("rx_valid", 8'h00, {7'h00, rx_valid});
    $display("test reset done");
  endtask

  // both directions at once in each parity mode
  task automatic t_duplex();
    int c;
    logic [7:0] d;
    for (int m = 0; m < 3; m++)
    begin
      @(posedge mclk);
      parity_en <= (m != 0);
      parity_odd <= (m == 2);
      settle(2);
      d = 8'h3C + 8'(m * 17);
      c = host.got_cnt;
      fork
        host.send(8'hA5 ^ 8'(m), 1'b0, 1'b0);
        tx_byte(d);
      join
      settle(BIT_CYC);
      check("host count", 8'(c + 1), 8'(host.got_cnt));
      check("host data", d, host.got);
      check("stop bit", 8'h01, {7'h00, host.got_stop});
      if (m != 0)
        check("parity", {7'h00, (^d) ^ (m == 2)},
              {7'h00, host.got_par});
      check("parity err", 8'h00, {7'h00, rx_parity_err});
      check("frame err", 8'h00, {7'h00, rx_frame_err});
      pop(8'hA5 ^ 8'(m));
    end
    $display("test duplex done");
  endtask

  task automatic t_cts();
    int lows;
    lows = 0;
    @(posedge mclk);
    cts_req <= HS_DEASSERT;
    // the port samples clear-to-send a cycle late; let it settle first
    repeat (2) @(posedge mclk);
    tx_data <= 8'h5A;
    tx_valid <= 1'b1;
    repeat (300)
    begin
      settle(1);
      if (uart_txd !== LINE_IDLE)
        lows++;
    end
    check("txd held", 8'h00, 8'(lows));
    check("ready held", 8'h01, {7'h00, tx_ready});
    @(posedge mclk);
    tx_valid <= 1'b0;
    cts_req <= HS_ASSERT;
    tx_byte(8'h5A);
    settle(12 * BIT_CYC);
    check("host data", 8'h5A, host.got);
    $display("test cts done");
  endtask

  task automatic t_parerr();
    host.send(8'h96, 1'b1, 1'b0);
    settle(BIT_CYC);
    check("parity err", 8'h01, {7'h00, rx_parity_err});
    pop(8'h96);
    $display("test parerr done");
  endtask

  task automatic t_fill();
    // one character waits in rx_data outside the counted buffer
    for (int i = 0; i < 13; i++)
      host.send(8'h10 + 8'(i), 1'b0, 1'b0);
    settle(20);
    check("rts full", 8'h01, {7'h00, uart_rts_n});
    for (int i = 13; i < 18; i++)
      host.send(8'h10 + 8'(i), 1'b0, 1'b1);
    settle(20);
    check("overrun", 8'h01, {7'h00, rx_overrun});
    for (int i = 0; i < 17; i++)
      pop(8'h10 + 8'(i));
    check("rts drained", 8'h00, {7'h00, uart_rts_n});
    @(posedge mclk);
    overrun_clr <= 1'b1;
    @(posedge mclk);
    overrun_clr <= 1'b0;
    settle(2);
    check("overrun clr", 8'h00, {7'h00, rx_overrun});
    $display("test fill done");
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    settle(3);
    t_reset();
    t_duplex();
    t_cts();
    t_parerr();
    t_fill();
    test_done();
  end

  // expected run is about 30000 cycles
  initial
  begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    $display("[FAIL] watchdog expected done seen timeout");
    test_done();
  end
endmodule
`default_nettype wire
